// ### shared/tspe_pkg.sv
// constants, register map and state codes of the table store and pop engine
// assumes one 40 MHz clock, synchronous active-low reset, 256-word data memory

package tspe_pkg;

  // ********************************************************************
  // widths
  // ********************************************************************
  localparam int MAW = 8;                        // data memory address width
  localparam int DW  = 16;                       // data word width
  localparam int BAW = 9;                        // bus address width

  // ********************************************************************
  // register map (bit 8 set selects registers, clear selects memory)
  // ********************************************************************
  localparam int              REG_SPACE_BIT = 8;      // register space select
  localparam logic [BAW-1:0]  OFS_LEN       = 9'h100; // table length (stack level one)
  localparam logic [BAW-1:0]  OFS_BASE      = 9'h101; // table base (accumulator)
  localparam logic [BAW-1:0]  OFS_OPND      = 9'h102; // source / destination word
  localparam logic [BAW-1:0]  OFS_CTRL      = 9'h103; // enabling input conditions
  localparam logic [BAW-1:0]  OFS_SCAN      = 9'h104; // write: start one scan
  localparam logic [BAW-1:0]  OFS_STAT      = 9'h105; // flag and busy

  // ********************************************************************
  // fields and reset values
  // ********************************************************************
  localparam int             CTRL_STORE_BIT = 0;      // store enable
  localparam int             CTRL_POP_BIT   = 1;      // pop enable
  localparam int             STAT_FLAG_BIT  = 0;      // table limit flag
  localparam int             STAT_BUSY_BIT  = 1;      // scan in progress
  localparam logic [MAW-1:0] BYTE_RST       = 8'h00;  // len/base/operand reset
  localparam logic [MAW-1:0] ONE_B          = 8'h01;  // first data slot, step
  localparam logic [DW-1:0]  ONE_W          = 16'h0001; // pointer restart, step
  localparam logic [DW-1:0]  ZERO_W         = 16'h0000; // empty word

  // ********************************************************************
  // sequencer states, one-hot
  // ********************************************************************
  typedef enum logic [10:0] {
    ST_IDLE  = 11'h001,  // waiting for a scan
    ST_S_RDP = 11'h002,  // store: read pointer
    ST_S_RDS = 11'h004,  // store: pointer back, read source
    ST_S_WRD = 11'h008,  // store: write slot
    ST_S_WRP = 11'h010,  // store: write pointer
    ST_P_RDC = 11'h020,  // pop: read counter
    ST_P_RDT = 11'h040,  // pop: counter back, read top
    ST_P_WRD = 11'h080,  // pop: write destination
    ST_P_RDN = 11'h100,  // pop: read next entry
    ST_P_WRN = 11'h200,  // pop: move entry up
    ST_P_WRC = 11'h400   // pop: write counter
  } tspe_state_t;

endpackage

// ### rtl/tspe_word_mem.sv
// word data memory of the engine: one write port, two registered read ports
// assumes writes come already arbitrated; port b may return an alternate word
`timescale 1ns/1ps

module tspe_word_mem (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // write port
  input  wire logic                      we,
  input  wire logic [tspe_pkg::MAW-1:0]  waddr,
  input  wire logic [tspe_pkg::DW-1:0]   wdata,
  // engine read port
  input  wire logic [tspe_pkg::MAW-1:0]  a_addr,
  output logic      [tspe_pkg::DW-1:0]   a_q,
  // bus read port
  input  wire logic                      b_rd,
  input  wire logic [tspe_pkg::MAW-1:0]  b_addr,
  input  wire logic                      b_alt_sel,
  input  wire logic [tspe_pkg::DW-1:0]   b_alt_data,
  output logic      [tspe_pkg::DW-1:0]   b_q
);
  import tspe_pkg::*;

  logic [DW-1:0] mem_arr [0:(1<<MAW)-1];  // word storage, no reset

  // ********************************************************************
  // storage and read registers
  // ********************************************************************
  // array write
  always_ff @(posedge clk) begin
    if (we) begin
      mem_arr[waddr] <= wdata;
    end
  end

  // engine read every cycle, bus read only on strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      a_q <= ZERO_W;
      b_q <= ZERO_W;
    end else begin
      a_q <= mem_arr[a_addr];
      b_q <= b_rd ? (b_alt_sel ? b_alt_data : mem_arr[b_addr]) : ZERO_W;
    end
  end

endmodule

// ### rtl/tspe_limit_flag.sv
// table limit flag: set by an operation, cleared at scan start or pop start
// assumes set and clear are one-cycle pulses from the sequencer
`timescale 1ns/1ps

module tspe_limit_flag (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // events
  input  wire logic set,
  input  wire logic clr,
  // state
  output logic      flag
);

  // ********************************************************************
  // flag register
  // ********************************************************************
  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

endmodule

// ### rtl/tspe_engine.sv
// table store and pop engine: circular store and pop-with-shift on word memory
// assumes a plain register port with one-cycle read latency and one clock
//
// Behaviour
// - store copies source, pointer increments by one
// - pointer at table end restarts at one
// - base word holds pointer, slots follow
// - pointer zero or length writes first slot
// - each enabled op runs once per scan
// - store reads value from source word
// - pointer beyond length moves no data
// - flag set when pointer reaches length
// - flag lasts until next scan start or pop start
// - pop copies top entry, shifts rest up
// - pop decrements base counter by one
// - counter zero or too big: skip, flag
// - flag set when counter reaches zero
// - slots past counter are not moved
// - pop writes removed value to destination
`timescale 1ns/1ps

module tspe_engine (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // register port
  input  wire logic [tspe_pkg::BAW-1:0]  addr,
  input  wire logic [tspe_pkg::DW-1:0]   wr_data,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [tspe_pkg::DW-1:0]   rd_data,
  // status
  output logic                           table_limit_flag,
  output logic                           busy_q
);
  import tspe_pkg::*;

  // ********************************************************************
  // helpers
  // ********************************************************************
  // slot written by a store for a given pointer
  function automatic logic [MAW-1:0] store_slot(input logic [DW-1:0] ptr,
                                                input logic [MAW-1:0] len);
    store_slot = (ptr == ZERO_W || ptr == {8'h00, len}) ? ONE_B
                                                        : MAW'(ptr + ONE_W);
  endfunction

  // pointer value after a store
  function automatic logic [DW-1:0] store_next(input logic [DW-1:0] ptr,
                                               input logic [MAW-1:0] len);
    store_next = (ptr == {8'h00, len}) ? ONE_W : DW'(ptr + ONE_W);
  endfunction

  // ********************************************************************
  // registers and wires
  // ********************************************************************
  logic [MAW-1:0] len_q;        // table length
  logic [MAW-1:0] base_q;       // table base address
  logic [MAW-1:0] opnd_q;       // source or destination word
  logic           store_en_q;   // store enabling condition
  logic           pop_en_q;     // pop enabling condition
  logic           pop_pend_q;   // pop still to run this scan
  tspe_state_t    state_q;      // sequencer state
  tspe_state_t    state_d;      // next state
  logic [DW-1:0]  word_q;       // pointer or counter of current op
  logic [MAW-1:0] idx_q;        // shift index
  logic [MAW-1:0] idx_d;        // next shift index
  logic [DW-1:0]  a_q;          // engine read data
  logic [MAW-1:0] a_addr;       // engine read address
  logic           eng_we;       // engine write
  logic [MAW-1:0] eng_waddr;    // engine write address
  logic [DW-1:0]  eng_wdata;    // engine write data
  logic           mem_we;       // arbitrated write
  logic [MAW-1:0] mem_waddr;    // arbitrated write address
  logic [DW-1:0]  mem_wdata;    // arbitrated write data
  logic [DW-1:0]  reg_rdata;    // register read mux
  logic [DW-1:0]  len_w;        // length widened to a word
  logic           is_idle;      // no scan running
  logic           is_reg;       // access to register space
  logic           cfg_wr;       // configuration write accepted
  logic           scan_go;      // scan start accepted
  logic           ptr_ok;       // store pointer within range
  logic           cnt_bad;      // pop counter out of range
  logic           store_done;   // store finished or skipped
  logic           shift_more;   // entries left to move up
  logic           flag_set;     // flag set event
  logic           flag_clr;     // flag clear event
  logic [DW-1:0]  ptr_new;      // pointer after store
  logic [DW-1:0]  cnt_new;      // counter after pop
  logic [MAW-1:0] slot_addr;    // store target address

  // ********************************************************************
  // decode
  // ********************************************************************
  assign len_w      = {8'h00, len_q};
  assign is_idle    = (state_q == ST_IDLE);
  assign is_reg     = addr[REG_SPACE_BIT];
  assign cfg_wr     = wr && is_idle;
  assign scan_go    = cfg_wr && (addr == OFS_SCAN);
  assign ptr_ok     = (a_q <= len_w);
  assign cnt_bad    = (a_q == ZERO_W) || (a_q > len_w);
  assign store_done = (state_q == ST_S_WRP) || ((state_q == ST_S_RDS) && !ptr_ok);
  assign shift_more = ({8'h00, idx_q} < word_q);
  assign ptr_new    = store_next(word_q, len_q);
  assign cnt_new    = DW'(word_q - ONE_W);
  assign slot_addr  = MAW'(base_q + store_slot(word_q, len_q));

  // ********************************************************************
  // configuration registers, writable between scans
  // ********************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      len_q      <= BYTE_RST;
      base_q     <= BYTE_RST;
      opnd_q     <= BYTE_RST;
      store_en_q <= 1'b0;
      pop_en_q   <= 1'b0;
    end else if (cfg_wr) begin
      if (addr == OFS_LEN)  len_q  <= wr_data[MAW-1:0];
      if (addr == OFS_BASE) base_q <= wr_data[MAW-1:0];
      if (addr == OFS_OPND) opnd_q <= wr_data[MAW-1:0];
      if (addr == OFS_CTRL) begin
        store_en_q <= wr_data[CTRL_STORE_BIT];
        pop_en_q   <= wr_data[CTRL_POP_BIT];
      end
    end
  end

  // ********************************************************************
  // sequencer
  // ********************************************************************
  // next state; every enabled op runs once per scan, no edge detection
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (scan_go && store_en_q) begin
          state_d = ST_S_RDP;
        end else if (scan_go && pop_en_q) begin
          state_d = ST_P_RDC;
        end
      end
      ST_S_RDP: state_d = ST_S_RDS;
      ST_S_RDS: begin
        if (ptr_ok) begin
          state_d = ST_S_WRD;
        end else begin
          state_d = pop_pend_q ? ST_P_RDC : ST_IDLE;
        end
      end
      ST_S_WRD: state_d = ST_S_WRP;
      ST_S_WRP: state_d = pop_pend_q ? ST_P_RDC : ST_IDLE;
      ST_P_RDC: state_d = ST_P_RDT;
      ST_P_RDT: state_d = cnt_bad ? ST_IDLE : ST_P_WRD;
      ST_P_WRD: state_d = ST_P_RDN;
      ST_P_RDN: state_d = shift_more ? ST_P_WRN : ST_P_WRC;
      ST_P_WRN: state_d = ST_P_RDN;
      ST_P_WRC: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // shift index steps once per moved entry
  assign idx_d = (state_q == ST_P_WRD) ? ONE_B :
                 (state_q == ST_P_WRN) ? MAW'(idx_q + ONE_B) : idx_q;

  // state, pending pop, working word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      pop_pend_q <= 1'b0;
      word_q     <= ZERO_W;
      idx_q      <= BYTE_RST;
      busy_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      idx_q      <= idx_d;
      busy_q     <= (state_d != ST_IDLE);
      if (scan_go) pop_pend_q <= pop_en_q;
      else if (state_q == ST_P_RDC) pop_pend_q <= 1'b0;
      if (state_q == ST_S_RDS || state_q == ST_P_RDT) word_q <= a_q;
    end
  end

  // ********************************************************************
  // memory access
  // ********************************************************************
  // engine read address per state
  assign a_addr = (state_q == ST_S_RDS) ? opnd_q :
                  (state_q == ST_P_RDT) ? MAW'(base_q + ONE_B) :
                  (state_q == ST_P_RDN) ? MAW'(base_q + idx_q + ONE_B) :
                  base_q;

  // engine writes: slot, pointer, destination, shifted entry, counter
  assign eng_we    = (state_q == ST_S_WRD) || (state_q == ST_S_WRP) || (state_q == ST_P_WRD) ||
                     (state_q == ST_P_WRN) || (state_q == ST_P_WRC);
  assign eng_waddr = (state_q == ST_S_WRD) ? slot_addr :
                     (state_q == ST_P_WRD) ? opnd_q :
                     (state_q == ST_P_WRN) ? MAW'(base_q + idx_q) :
                     base_q;
  assign eng_wdata = (state_q == ST_S_WRP) ? ptr_new :
                     (state_q == ST_P_WRC) ? cnt_new :
                     a_q;

  // bus writes reach memory only between scans
  assign mem_we    = is_idle ? (wr && !is_reg) : eng_we;
  assign mem_waddr = is_idle ? addr[MAW-1:0] : eng_waddr;
  assign mem_wdata = is_idle ? wr_data : eng_wdata;

  // register read mux, unmapped reads zero
  assign reg_rdata = (addr == OFS_LEN)  ? len_w :
                     (addr == OFS_BASE) ? {8'h00, base_q} :
                     (addr == OFS_OPND) ? {8'h00, opnd_q} :
                     (addr == OFS_CTRL) ? DW'({pop_en_q, store_en_q}) :
                     (addr == OFS_STAT) ? DW'({busy_q, table_limit_flag}) :
                     ZERO_W;

  // word memory, bus read data come from its output register
  tspe_word_mem u_mem (
    .clk        (clk),
    .rst_n      (rst_n),
    .we         (mem_we),
    .waddr      (mem_waddr),
    .wdata      (mem_wdata),
    .a_addr     (a_addr),
    .a_q        (a_q),
    .b_rd       (rd),
    .b_addr     (addr[MAW-1:0]),
    .b_alt_sel  (is_reg),
    .b_alt_data (reg_rdata),
    .b_q        (rd_data)
  );

  // ********************************************************************
  // table limit flag
  // ********************************************************************
  assign flag_set = ((state_q == ST_S_WRP) && (ptr_new == len_w)) ||
                    ((state_q == ST_P_RDT) && cnt_bad) ||
                    ((state_q == ST_P_WRC) && (cnt_new == ZERO_W));
  assign flag_clr = scan_go || (state_q == ST_P_RDC);

  tspe_limit_flag u_flag (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (flag_set),
    .clr   (flag_clr),
    .flag  (table_limit_flag)
  );

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_ptr_in;
    (state_q == ST_S_RDS) && ptr_ok;
  endsequence
  sequence s_slot_wr;
    (state_q == ST_S_WRD) && eng_we;
  endsequence

  property p_store_slot;
    s_ptr_in ##1 s_slot_wr |-> mem_waddr == MAW'(base_q + store_slot($past(a_q), len_q));
  endproperty
  a_store_slot: assert property (p_store_slot) else $error("store slot wrong");

  property p_store_ptr;
    s_ptr_in |-> ##2 (mem_waddr == base_q && mem_wdata == store_next($past(a_q, 2), len_q));
  endproperty
  a_store_ptr: assert property (p_store_ptr) else $error("store pointer wrong");

  property p_store_src;
    s_ptr_in ##1 s_slot_wr |-> mem_wdata == a_q && $past(a_addr) == opnd_q;
  endproperty
  a_store_src: assert property (p_store_src) else $error("store source wrong");

  property p_range_skip;
    (state_q == ST_S_RDS) && !ptr_ok |=> !eng_we ##1 state_q != ST_S_WRP;
  endproperty
  a_range_skip: assert property (p_range_skip) else $error("out of range store moved data");

  property p_store_flag;
    (state_q == ST_S_WRP) && (mem_wdata == len_w) |=> table_limit_flag;
  endproperty
  a_store_flag: assert property (p_store_flag) else $error("flag missing after store");

  property p_scan_clear;
    scan_go |=> !table_limit_flag;
  endproperty
  a_scan_clear: assert property (p_scan_clear) else $error("flag survived scan start");

  property p_scan_runs;
    scan_go && store_en_q |=> state_q == ST_S_RDP ##1 state_q == ST_S_RDS;
  endproperty
  a_scan_runs: assert property (p_scan_runs) else $error("enabled store did not run");

  property p_pop_skip;
    (state_q == ST_P_RDT) && cnt_bad |=> table_limit_flag && !eng_we && is_idle;
  endproperty
  a_pop_skip: assert property (p_pop_skip) else $error("bad counter not skipped");

  property p_pop_dest;
    (state_q == ST_P_WRD) |-> mem_waddr == opnd_q && $past(a_addr) == MAW'(base_q + ONE_B);
  endproperty
  a_pop_dest: assert property (p_pop_dest) else $error("pop destination wrong");

  property p_pop_keep;
    (state_q == ST_P_WRN) |-> ({8'h00, mem_waddr - base_q} < word_q);
  endproperty
  a_pop_keep: assert property (p_pop_keep) else $error("slot at counter overwritten");

  property p_pop_cnt;
    (state_q == ST_P_WRC) |-> mem_wdata == DW'(word_q - ONE_W) ##1 (table_limit_flag == (word_q == ONE_W));
  endproperty
  a_pop_cnt: assert property (p_pop_cnt) else $error("pop counter or flag wrong");

endmodule

// ### test/tspe_prog_model.sv
// program sequencer model: drives the register port as controller code would
// assumes reads answer one cycle after the strobe and the engine never stalls
`timescale 1ns/1ps

module tspe_prog_model (
  // clock
  input  wire logic                     clk,
  // register port
  output logic [tspe_pkg::BAW-1:0]      addr,
  output logic [tspe_pkg::DW-1:0]       wr_data,
  output logic                          wr,
  output logic                          rd,
  input  wire logic [tspe_pkg::DW-1:0]  rd_data,
  input  wire logic                     busy_q
);
  import tspe_pkg::*;

  // ********************************************************************
  // bus cycles
  // ********************************************************************
  // idle port from time zero
  initial begin
    addr = '0;
    wr_data = '0;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one write cycle, data inverted once released
  task automatic put(input logic [BAW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wr_data <= ~d;
  endtask

  // one read cycle, data taken in the answer cycle
  task automatic get(input logic [BAW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // table parameters as the program loads them
  task automatic setup(input logic [7:0] len, input logic [7:0] base, input logic [7:0] opnd);
    put(OFS_LEN, {8'h00, len});
    put(OFS_BASE, {8'h00, base});
    put(OFS_OPND, {8'h00, opnd});
  endtask

  // one scan with the chosen ops enabled, waits for idle
  // a scan that never ends is left to the bench watchdog, which fails the run
  task automatic scan(input logic [1:0] ops);
    put(OFS_CTRL, {14'h0000, ops});
    put(OFS_SCAN, ONE_W);
    #1;
    while (busy_q !== 1'b0) begin
      @(posedge clk);
      #1;
    end
  endtask
endmodule

// ### test/test_table_store_and_pop_engine.sv
// self-checking bench: store and pop scans on the table engine
// assumes the engine's register map and one 40 MHz clock
`timescale 1ns/1ps

module test_table_store_and_pop_engine;
  import tspe_pkg::*;

  // ********************************************************************
  // signals
  // ********************************************************************
  logic            clk;
  logic            rst_n;
  logic [BAW-1:0]  addr;
  logic [DW-1:0]   wr_data;
  logic            wr;
  logic            rd;
  logic [DW-1:0]   rd_data;
  logic            table_limit_flag;
  logic            busy_q;
  int              err_count;
  int              comparisons;

  tspe_engine tspe_engine_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr(wr),
    .rd(rd), .rd_data(rd_data), .table_limit_flag(table_limit_flag), .busy_q(busy_q));
  tspe_prog_model tspe_prog_model_i (.clk(clk), .addr(addr), .wr_data(wr_data), .wr(wr), .rd(rd),
    .rd_data(rd_data), .busy_q(busy_q));

  // ********************************************************************
  // helpers
  // ********************************************************************
  // compare and count
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // read a word and compare
  task automatic chk_rd(input logic [BAW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] d;
    tspe_prog_model_i.get(a, d);
    check(d, exp);
  endtask

  // memory word write and check
  task automatic mput(input logic [7:0] a, input logic [DW-1:0] d);
    tspe_prog_model_i.put({1'b0, a}, d);
  endtask
  task automatic chk_mem(input logic [7:0] a, input logic [DW-1:0] exp);
    chk_rd({1'b0, a}, exp);
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ********************************************************************
  // scenarios
  // ********************************************************************
  // idle state after reset, unmapped read
  task automatic reset_values();
    chk_rd(OFS_STAT, ZERO_W);
    chk_rd(OFS_LEN, ZERO_W);
    chk_rd(9'h1ff, ZERO_W);
  endtask

  // circular store through a wrap, then out-of-range pointer
  task automatic store_circular();
    logic [7:0] p;
    logic [7:0] slot;
    p = 8'h00;
    tspe_prog_model_i.setup(8'h03, 8'h10, 8'h40);
    mput(8'h10, ZERO_W);
    for (int i = 0; i < 4; i++) begin
      mput(8'h40, 16'ha500 + 16'(i));
      tspe_prog_model_i.scan(2'b01);
      slot = (p == 8'h00 || p == 8'h03) ? 8'h11 : 8'h11 + p;
      p = (p == 8'h03) ? 8'h01 : p + 8'h01;
      chk_mem(slot, 16'ha500 + 16'(i));
      chk_mem(8'h10, {8'h00, p});
      check({15'h0, table_limit_flag}, {15'h0, p == 8'h03});
    end
    tspe_prog_model_i.scan(2'b00);
    check({15'h0, table_limit_flag}, ZERO_W);
    mput(8'h10, 16'h0005);
    tspe_prog_model_i.scan(2'b01);
    chk_mem(8'h11, 16'ha503);
    chk_mem(8'h10, 16'h0005);
    check({15'h0, table_limit_flag}, ZERO_W);
  endtask

  // pop with partial shift down to empty, then bad counters
  task automatic pop_shift();
    logic [DW-1:0] e [6];
    for (int j = 0; j < 6; j++) begin
      e[j] = 16'hb001 + 16'(j);
      mput(8'h21 + 8'(j), e[j]);
    end
    tspe_prog_model_i.setup(8'h06, 8'h20, 8'h50);
    mput(8'h20, 16'h0004);
    for (int k = 4; k > 0; k--) begin
      tspe_prog_model_i.scan(2'b10);
      chk_mem(8'h50, e[0]);
      for (int j = 0; j < k - 1; j++) begin
        e[j] = e[j + 1];
      end
      for (int j = 0; j < 6; j++) begin
        chk_mem(8'h21 + 8'(j), e[j]);
      end
      chk_mem(8'h20, 16'(k - 1));
      check({15'h0, table_limit_flag}, {15'h0, k == 1});
    end
    mput(8'h50, ZERO_W);
    tspe_prog_model_i.scan(2'b10);
    check({15'h0, table_limit_flag}, ONE_W);
    chk_mem(8'h50, ZERO_W);
    mput(8'h20, 16'h0007);
    tspe_prog_model_i.scan(2'b10);
    check({15'h0, table_limit_flag}, ONE_W);
    chk_mem(8'h20, 16'h0007);
    chk_mem(8'h21, e[0]);
  endtask

  // store then pop in one scan, both sharing one base word
  task automatic both_ops();
    tspe_prog_model_i.setup(8'h02, 8'h30, 8'h60);
    mput(8'h30, ONE_W);
    mput(8'h31, 16'h1111);
    mput(8'h32, 16'h2222);
    mput(8'h60, 16'hc0de);
    tspe_prog_model_i.scan(2'b11);
    check({15'h0, busy_q}, ZERO_W);
    chk_mem(8'h60, 16'h1111);
    chk_mem(8'h31, 16'hc0de);
    chk_mem(8'h32, 16'hc0de);
    chk_mem(8'h30, ONE_W);
    check({15'h0, table_limit_flag}, ZERO_W);
    chk_rd(OFS_STAT, ZERO_W);
  endtask

  // ********************************************************************
  // clock, watchdog, main sequence
  // ********************************************************************
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // watchdog, far beyond the few hundred cycles the scenarios need
  initial begin
    #500000;
    err_count++;
    stop_test();
  end

  // reset for ten cycles, then the scenarios
  initial begin
    err_count = 0;
    comparisons = 0;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reset_values();
    store_circular();
    pop_shift();
    both_ops();
    stop_test();
  end
endmodule
